// >>> optstrap_pkg.sv
// constants and carrier types for the option strap control logic
// assumes one processor clock; straps and secondary switches arrive active low, console switches active high
// What this block does
// R1: default: power-fail, console, trap interrupts need global enable on
// R2: independent strap: processor interrupts need only their own enables
// R3: strap grounded: power-fail, console gated by own enables; trap ungated
// R4: offset adds 0x100 to shifted vectors; power-up and other vectors never move
// R5: high offset strap shifts power-fail, console, trap, both user levels
// R6: low offset strap shifts terminal and clock option vectors independently
// R7: sense word is four bits, jumper zero is lsb, jumper three msb
// R8: grounded jumper reads 1, open jumper reads 0
// R9: sense word takes part in sense reads only while enable strap grounded
// R10: answer sense-to-accumulator 0x5801 and sense-to-index 0x5a01
// R11: integrator leaves jumper sense disabled when a real console is fitted
// R12: secondary sense, reset, int inputs mirror console switches, active low
// R13: external party holds secondary reset low at least 5 us
// R14: secondary sense is a level held low while sense is active
// R15: each secondary switch is ORed with its console switch
// R16: four stretch straps select one of 16 stretch settings
// R17: stretch step 200 ns slow variant, 100 ns fast variant
// R18: binary code, strap bit3 msb, grounded is 1; stretch is code times step
// R19: any nonzero stretch lengthens every bus transfer
// R20: inputs active low, two-flop synchronised, stretch in whole clock cycles
// R21: secondary reset drives system reset after minimum low time
package optstrap_pkg;

    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          SLOW_STEP_NS     = 200;
    localparam int          FAST_STEP_NS     = 100;
    localparam int          SLOW_STEP_CYC    =
        (SLOW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          FAST_STEP_CYC    =
        (FAST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RESET_MIN_US     = 5;
    localparam int          RESET_MIN_CYC    = (RESET_MIN_US * 1000
                                               + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
    localparam logic [15:0] VEC_OFFSET       = 16'h0100;
    localparam logic [15:0] INSTR_SENSE_ACC  = 16'h5801;
    localparam logic [15:0] INSTR_SENSE_IDX  = 16'h5a01;
    localparam logic [3:0]  STRETCH_MAX_CODE = 4'hf;

    // vector classes the processor asks to be mapped
    typedef enum logic [2:0] {
        VEC_POWER_UP  = 3'b000,
        VEC_HIGH_PROC = 3'b001,
        VEC_HIGH_USER = 3'b010,
        VEC_LOW_OPT   = 3'b011,
        VEC_OTHER     = 3'b100
    } vec_class_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_STRETCH = 2'b01,
        ST_DONE    = 2'b10
    } io_state_t;

    // synchronised, active-high copies of the pins
    typedef struct packed {
        logic       indep;
        logic       high_shift;
        logic       low_shift;
        logic       sense_en;
        logic [3:0] jumpers;
        logic       sec_sense;
        logic       sec_reset;
        logic       sec_int;
        logic [3:0] stretch;
    } straps_t;

    // processor-side interrupt requests and enables
    typedef struct packed {
        logic pf_req;
        logic con_req;
        logic trap_req;
        logic global_en;
        logic pf_en_instr;
        logic pf_dis_instr;
        logic con_en_instr;
        logic con_dis_instr;
    } irq_in_t;

    typedef struct packed {
        logic pf_take;
        logic con_take;
        logic trap_take;
    } irq_out_t;

    typedef struct packed {
        logic       sense_valid;
        logic       to_acc;
        logic       to_idx;
        logic [3:0] sense_word;
    } sense_out_t;

endpackage

// >>> optstrap_ctrl.sv
// option strap control logic: interrupt gating, vector shift, jumper
// sense word, secondary switches and i/o transfer stretch
// assumes processor-side strobes are synchronous one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module optstrap_ctrl #(
    parameter bit FAST_VARIANT  = 1'b0,
    parameter int RESET_CYCLES  = optstrap_pkg::RESET_MIN_CYC
) (
    input  wire logic                     CLK,            // processor clock
    input  wire logic                     RESETN,         // async reset, low
    input  wire logic                     INDEP_N,        // independent strap
    input  wire logic                     HIGH_SHIFT_N,   // high vector shift
    input  wire logic                     LOW_SHIFT_N,    // low vector shift
    input  wire logic                     SENSE_EN_N,     // jumper enable
    input  wire logic [3:0]               JUMPER_N,       // sense jumpers
    input  wire logic                     SEC_SENSE_N,    // secondary sense
    input  wire logic                     SEC_RESET_N,    // secondary reset
    input  wire logic                     SEC_INT_N,      // secondary interrupt
    input  wire logic [3:0]               STRETCH_N,      // stretch straps
    input  wire logic                     CON_SENSE,      // console sense sw
    input  wire logic                     CON_RESET,      // console reset sw
    input  wire logic                     CON_INT,        // console int sw
    input  wire optstrap_pkg::irq_in_t    IRQ_IN,         // irq requests
    input  wire optstrap_pkg::vec_class_t VEC_CLASS,      // vector class
    input  wire logic [15:0]              VEC_IN,         // base vector
    input  wire logic                     INSTR_VALID,    // instr strobe
    input  wire logic [15:0]              INSTR,          // instr word
    input  wire logic                     IO_START,       // bus transfer start
    output optstrap_pkg::irq_out_t        IRQ_OUT,        // irq recognised
    output logic [15:0]                   VEC_OUT,        // mapped vector
    output optstrap_pkg::sense_out_t      SENSE_OUT,      // sense read answer
    output logic                          SENSE_SWITCH,   // merged sense
    output logic                          INT_SWITCH,     // merged interrupt
    output logic                          SYS_RESET,      // sync system reset
    output logic                          IO_DONE,        // transfer may end
    output logic                          IO_BUSY         // stretch running
);
    import optstrap_pkg::*;

    localparam int STEP_CYC  = FAST_VARIANT ? FAST_STEP_CYC : SLOW_STEP_CYC;
    localparam int CNT_W     = 16;

    // refuse counts that the 16-bit counters cannot hold
    if (RESET_CYCLES < 1 || RESET_CYCLES > 65535 ||
        STEP_CYC * 15 > 65535) begin
        $error("optstrap_ctrl: counts do not fit counter width");
    end

    typedef struct packed {
        logic [1:0]       rst_sync;
        straps_t          s1;
        straps_t          s2;
        logic             pf_en;
        logic             con_en;
        logic [CNT_W-1:0] rst_cnt;
        logic             sys_reset;
        io_state_t        io_state;
        logic [CNT_W-1:0] io_cnt;
        logic [15:0]      vec;
        sense_out_t       sense;
        irq_out_t         irq;
        logic             sense_sw;
        logic             int_sw;
    } state_t;

    state_t st;
    state_t next_st;
    logic   rst_n;

    // stretch cycles for a given strap code
    function automatic logic [CNT_W-1:0] stretch_cycles(input logic [3:0] c);
        stretch_cycles = CNT_W'(c) * CNT_W'(STEP_CYC);         // R18 R20
    endfunction

    // reset release through two flops; only the second is used
    assign rst_n = st.rst_sync[1];

    always_comb begin
        next_st          = st;
        next_st.rst_sync = {st.rst_sync[0], 1'b1};
        // invert to active high, first flop feeds only the second
        next_st.s1 = '{indep:      ~INDEP_N,
                       high_shift: ~HIGH_SHIFT_N,
                       low_shift:  ~LOW_SHIFT_N,
                       sense_en:   ~SENSE_EN_N,
                       jumpers:    ~JUMPER_N,                  // R8
                       sec_sense:  ~SEC_SENSE_N,
                       sec_reset:  ~SEC_RESET_N,
                       sec_int:    ~SEC_INT_N,
                       stretch:    ~STRETCH_N};                // R20
        next_st.s2 = st.s1;                                    // R20

        // per-interrupt enables for the independent mode
        if (IRQ_IN.pf_en_instr) begin
            next_st.pf_en = 1'b1;                              // R3
        end else if (IRQ_IN.pf_dis_instr) begin
            next_st.pf_en = 1'b0;                              // R3
        end
        if (IRQ_IN.con_en_instr) begin
            next_st.con_en = 1'b1;                             // R3
        end else if (IRQ_IN.con_dis_instr) begin
            next_st.con_en = 1'b0;                             // R3
        end

        if (st.s2.indep) begin
            // trap has no enable of its own beyond the instruction
            next_st.irq.pf_take   = IRQ_IN.pf_req && st.pf_en;     // R2 R3
            next_st.irq.con_take  = IRQ_IN.con_req && st.con_en;   // R2 R3
            next_st.irq.trap_take = IRQ_IN.trap_req;               // R2 R3
        end else begin
            next_st.irq.pf_take   = IRQ_IN.pf_req && IRQ_IN.global_en;  // R1
            next_st.irq.con_take  = IRQ_IN.con_req && IRQ_IN.global_en; // R1
            next_st.irq.trap_take = IRQ_IN.trap_req && IRQ_IN.global_en; // R1
        end

        // vector relocation
        next_st.vec = VEC_IN;
        case (VEC_CLASS)
            VEC_HIGH_PROC, VEC_HIGH_USER: begin
                if (st.s2.high_shift) begin
                    next_st.vec = VEC_IN + VEC_OFFSET;         // R4 R5
                end
            end
            VEC_LOW_OPT: begin
                if (st.s2.low_shift) begin
                    next_st.vec = VEC_IN + VEC_OFFSET;         // R4 R6
                end
            end
            default: begin
                next_st.vec = VEC_IN;                          // R4
            end
        endcase

        // jumper sense word answers only while enabled
        next_st.sense.to_acc     = INSTR_VALID && st.s2.sense_en &&
                                   INSTR == INSTR_SENSE_ACC;   // R10 R9
        next_st.sense.to_idx     = INSTR_VALID && st.s2.sense_en &&
                                   INSTR == INSTR_SENSE_IDX;   // R10 R9
        next_st.sense.sense_valid = next_st.sense.to_acc ||
                                    next_st.sense.to_idx;
        next_st.sense.sense_word = st.s2.sense_en ?
                                   st.s2.jumpers : 4'h0;       // R7 R9

        next_st.sense_sw = CON_SENSE || st.s2.sec_sense;       // R12 R15
        next_st.int_sw   = CON_INT || st.s2.sec_int;           // R12 R15

        // secondary reset qualified by its minimum low time
        if (st.s2.sec_reset) begin
            if (st.rst_cnt < CNT_W'(RESET_CYCLES)) begin
                next_st.rst_cnt = st.rst_cnt + 16'h0001;       // R21
            end
        end else begin
            next_st.rst_cnt = '0;
        end
        next_st.sys_reset = CON_RESET ||
                            (st.s2.sec_reset &&
                             st.rst_cnt >= CNT_W'(RESET_CYCLES) - 16'h0001);
                                                               // R21 R15
        // every transfer is stretched by the same strap code
        case (st.io_state)
            ST_IDLE: begin
                if (IO_START) begin
                    next_st.io_cnt = stretch_cycles(st.s2.stretch); // R16 R17
                    next_st.io_state = ST_STRETCH;             // R19
                end
            end
            ST_STRETCH: begin
                if (st.io_cnt == '0) begin
                    next_st.io_state = ST_DONE;
                end else begin
                    next_st.io_cnt = st.io_cnt - 16'h0001;     // R18
                end
            end
            ST_DONE: begin
                next_st.io_state = ST_IDLE;
            end
            default: begin
                next_st.io_state = ST_IDLE;
            end
        endcase

        // hold all but the reset flops until the released copy is high;
        // one register process keeps the state a single driver
        if (!rst_n) begin
            next_st          = '0;
            next_st.rst_sync = {st.rst_sync[0], 1'b1};
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign IRQ_OUT      = st.irq;
    assign VEC_OUT      = st.vec;
    assign SENSE_OUT    = st.sense;
    assign SENSE_SWITCH = st.sense_sw;
    assign INT_SWITCH   = st.int_sw;
    assign SYS_RESET    = st.sys_reset;
    assign IO_DONE      = st.io_state == ST_DONE;
    assign IO_BUSY      = st.io_state == ST_STRETCH;
endmodule
`default_nettype wire

// >>> optstrap_chk.sv
// port checker for the option strap control logic
// bound to optstrap_ctrl; straps assumed static for four edges
`timescale 1ns/1ps
`default_nettype none
module optstrap_chk
    import optstrap_pkg::*;
(
    input wire logic                     CLK,          // clock
    input wire logic                     RESETN,       // reset, low
    input wire logic                     INDEP_N,      // strap pin
    input wire logic                     SENSE_EN_N,   // strap pin
    input wire optstrap_pkg::irq_in_t    IRQ_IN,       // irq inputs
    input wire optstrap_pkg::vec_class_t VEC_CLASS,    // vector class
    input wire logic [15:0]              VEC_IN,       // base vector
    input wire logic                     INSTR_VALID,  // instr strobe
    input wire logic [15:0]              INSTR,        // instr word
    input wire logic                     CON_INT,      // console int
    input wire logic                     IO_START,     // transfer start
    input wire optstrap_pkg::irq_out_t   IRQ_OUT,      // irq taken
    input wire logic [15:0]              VEC_OUT,      // mapped vector
    input wire optstrap_pkg::sense_out_t SENSE_OUT,    // sense answer
    input wire logic                     INT_SWITCH,   // merged int
    input wire logic                     IO_DONE,      // transfer end
    input wire logic                     IO_BUSY       // stretching
);
    logic [2:0] warm;
    // the internal reset copy trails the pin, so hold off a few edges
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN)
            warm <= 3'h0;
        else if (warm != 3'h7)
            warm <= warm + 3'h1;
    end
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RESETN || warm < 3'h5);
    sequence indep_open; INDEP_N [*4]; endsequence
    sequence sense_on; !SENSE_EN_N [*4]; endsequence
    a_gate_default_off:
        assert property (indep_open ##0 !IRQ_IN.global_en |=> !(|IRQ_OUT))
        else $error("irq taken while global enable off");
    a_trap_cause:
        assert property (IRQ_OUT.trap_take |-> $past(IRQ_IN.trap_req))
        else $error("trap taken without request");
    a_vec_unshifted:
        assert property (VEC_CLASS inside {VEC_POWER_UP, VEC_OTHER}
            |=> VEC_OUT == $past(VEC_IN)) else $error("vector moved");
    a_vec_span:
        assert property (1'b1 |=> VEC_OUT == $past(VEC_IN)
            || VEC_OUT == $past(VEC_IN) + VEC_OFFSET)
        else $error("vector shifted by wrong amount");
    a_sense_acc:
        assert property (sense_on ##0 INSTR_VALID && INSTR == INSTR_SENSE_ACC
            |=> SENSE_OUT.sense_valid && SENSE_OUT.to_acc)
        else $error("accumulator sense read not answered");
    a_sense_off:
        assert property (SENSE_EN_N [*4] |=> !SENSE_OUT.sense_valid)
        else $error("sense answered while disabled");
    a_int_merge:
        assert property (CON_INT |=> INT_SWITCH)
        else $error("console int not merged");
    a_start_busy:
        assert property (IO_START && !IO_BUSY && !IO_DONE |=> IO_BUSY)
        else $error("transfer start not stretched");
    a_done_once:
        assert property (IO_DONE |=> !IO_DONE && !IO_BUSY)
        else $error("done longer than one cycle");
endmodule
`default_nettype wire

// >>> strap_field.sv
// far side model: straps and switch closures to ground
// open pins float to the pull-up level, never to the last value
`timescale 1ns/1ps
`default_nettype none
module strap_field
    import optstrap_pkg::*;
(
    input  wire optstrap_pkg::straps_t gnd,    // 1 = closed to ground
    output var  optstrap_pkg::straps_t pins_n  // pin levels
);
    assign pins_n = ~gnd;
endmodule
`default_nettype wire

// >>> option_strap_control_logic_tb.sv
// self-checking bench for optstrap_ctrl with a strap field model
// slow variant, secondary reset threshold shortened to 3 cycles
`timescale 1ns/1ps
`default_nettype none
module option_strap_control_logic_tb;
    import optstrap_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, con_sense = 1'b0, con_reset = 1'b0;
    logic con_int = 1'b0, instr_valid = 1'b0, io_start = 1'b0;
    logic sense_sw, int_sw, sys_reset, io_done, io_busy, seen;
    logic [15:0] vec_in = 16'h0, instr = 16'h0, vec_out;
    straps_t gnd = '0, pins_n;
    irq_in_t irq_in = '0;
    vec_class_t vec_class = VEC_POWER_UP;
    irq_out_t irq_out;
    sense_out_t sense_out;
    int miscompares = 0, checked = 0;
    always #50 clk = ~clk;
    strap_field strap_field_i (.gnd(gnd), .pins_n(pins_n));
    optstrap_ctrl #(.FAST_VARIANT(1'b0), .RESET_CYCLES(3)) optstrap_ctrl_i (
        .CLK(clk), .RESETN(rstn), .INDEP_N(pins_n.indep),
        .HIGH_SHIFT_N(pins_n.high_shift), .LOW_SHIFT_N(pins_n.low_shift),
        .SENSE_EN_N(pins_n.sense_en), .JUMPER_N(pins_n.jumpers),
        .SEC_SENSE_N(pins_n.sec_sense), .SEC_RESET_N(pins_n.sec_reset),
        .SEC_INT_N(pins_n.sec_int), .STRETCH_N(pins_n.stretch),
        .CON_SENSE(con_sense), .CON_RESET(con_reset), .CON_INT(con_int),
        .IRQ_IN(irq_in), .VEC_CLASS(vec_class), .VEC_IN(vec_in),
        .INSTR_VALID(instr_valid), .INSTR(instr), .IO_START(io_start),
        .IRQ_OUT(irq_out), .VEC_OUT(vec_out), .SENSE_OUT(sense_out),
        .SENSE_SWITCH(sense_sw), .INT_SWITCH(int_sw), .SYS_RESET(sys_reset),
        .IO_DONE(io_done), .IO_BUSY(io_busy));
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_vec();
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            gnd.high_shift <= s[0];
            gnd.low_shift <= s[1];
            wt(5);
            for (int k = 0; k < 5; k++) begin
                @(posedge clk);
                vec_class <= vec_class_t'(k);
                vec_in <= 16'h0018 + 16'(k);
                wt(1);
                chk(vec_out, 16'h0018 + 16'(k) + (((k inside {1, 2}) && s[0])
                    || (k == 3 && s[1]) ? VEC_OFFSET : 16'h0));
            end
        end
        $display("vector test done");
    endtask
    // enable/disable strobes are dropped after one cycle
    task automatic irq_step(input irq_in_t v, input logic [2:0] exp);
        @(posedge clk);
        irq_in <= v;
        @(posedge clk);
        irq_in <= irq_in_t'(v & 8'hf0);
        wt(2);
        chk({13'h0, irq_out}, {13'h0, exp});
    endtask
    task automatic t_irq();
        irq_step(8'he0, 3'h0);
        irq_step(8'hf0, 3'h7);
        @(posedge clk);
        gnd.indep <= 1'b1;
        wt(5);
        irq_step(8'he0, 3'h1);
        irq_step(8'he8, 3'h5);
        irq_step(8'he2, 3'h7);
        irq_step(8'he4, 3'h3);
        irq_step(8'he1, 3'h1);
        $display("interrupt test done");
    endtask
    task automatic sense_rd(input logic [15:0] op, input logic [6:0] exp);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= op;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk({9'h0, sense_out}, {9'h0, exp});
    endtask
    task automatic t_sense();
        @(posedge clk);
        gnd.jumpers <= 4'ha;
        wt(5);
        sense_rd(INSTR_SENSE_ACC, 7'h00);
        @(posedge clk);
        gnd.sense_en <= 1'b1;
        wt(5);
        sense_rd(INSTR_SENSE_ACC, 7'h6a);
        sense_rd(16'h5802, 7'h0a);
        @(posedge clk);
        gnd.jumpers <= 4'h5;
        wt(5);
        sense_rd(INSTR_SENSE_IDX, 7'h55);
        $display("sense test done");
    endtask
    task automatic t_stretch(input logic [3:0] code);
        int n;
        @(posedge clk);
        gnd.stretch <= code;
        wt(5);
        @(posedge clk);
        io_start <= 1'b1;
        @(posedge clk);
        io_start <= 1'b0;
        #1;
        n = 0;
        while (io_busy === 1'b1 && n < 40) begin
            n++;
            wt(1);
        end
        chk(16'(n), 16'(code) * 16'(SLOW_STEP_CYC) + 16'h1);
        chk({15'h0, io_done}, 16'h1);
        $display("stretch test done");
    endtask
    task automatic poll_reset(input int n);
        seen = 1'b0;
        repeat (n) begin
            wt(1);
            seen = seen | sys_reset;
        end
    endtask
    task automatic t_switch();
        @(posedge clk);
        gnd.sec_sense <= 1'b1;
        gnd.sec_int <= 1'b1;
        wt(4);
        chk({14'h0, sense_sw, int_sw}, 16'h3);
        @(posedge clk);
        gnd.sec_sense <= 1'b0;
        gnd.sec_int <= 1'b0;
        con_sense <= 1'b1;
        wt(4);
        chk({14'h0, sense_sw, int_sw}, 16'h2);
        @(posedge clk);
        con_sense <= 1'b0;
        con_int <= 1'b1;
        con_reset <= 1'b1;
        wt(2);
        chk({14'h0, sense_sw, int_sw}, 16'h1);
        chk({15'h0, sys_reset}, 16'h1);
        @(posedge clk);
        con_int <= 1'b0;
        con_reset <= 1'b0;
        gnd.sec_reset <= 1'b1;
        // one cycle short of the threshold must not reset
        repeat (2) @(posedge clk);
        gnd.sec_reset <= 1'b0;
        poll_reset(12);
        chk({15'h0, seen}, 16'h0);
        @(posedge clk);
        gnd.sec_reset <= 1'b1;
        poll_reset(12);
        chk({15'h0, seen}, 16'h1);
        $display("switch test done");
    endtask
    initial begin
        wt(10);
        rstn <= 1'b1;
        wt(5);
        t_vec();
        t_irq();
        t_sense();
        t_stretch(4'h0);
        t_stretch(4'h2);
        t_stretch(4'hf);
        t_switch();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule
bind optstrap_ctrl optstrap_chk optstrap_chk_i (
    .CLK(CLK), .RESETN(RESETN), .INDEP_N(INDEP_N), .SENSE_EN_N(SENSE_EN_N),
    .IRQ_IN(IRQ_IN), .VEC_CLASS(VEC_CLASS), .VEC_IN(VEC_IN),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .CON_INT(CON_INT),
    .IO_START(IO_START), .IRQ_OUT(IRQ_OUT), .VEC_OUT(VEC_OUT),
    .SENSE_OUT(SENSE_OUT), .INT_SWITCH(INT_SWITCH), .IO_DONE(IO_DONE),
    .IO_BUSY(IO_BUSY));
`default_nettype wire
